// File: design/uls_line_status.sv
// serial line status word, its flags, clears and interrupt conditions
// Function
// - without fifo mode the receive error summary bit 7 always reads 0.
// - in fifo mode bit 7 is set while any held character carries a parity, framing or break error.
// - a status read clears bit 7 unless erroneous characters still remain in the fifo.
// - bit 6 is read only, resets to 1, and is 1 only while holding and shift registers are both empty.
// - bit 5 is read only, resets to 1, and sets when a character moves from holding to shift register.
// - setting bit 5 raises the priority-3 transmitter condition, cleared by an identification read that reports it.
// - in fifo mode bit 5 sets when the transmit fifo empties and clears when a byte is written.
// - bit 4 sets when the serial input stays low for longer than a whole character time.
// - when any of bits 1 to 4 sets with line status enable on, the priority-1 condition is raised.
// - bit 3 sets on an invalid stop bit and a status read clears it.
// - bit 2 sets on a parity failure of the chosen parity sense and a status read clears it.
// - without fifo mode bit 1 sets when an unread buffer is overwritten; a status read clears it.
// - in fifo mode bit 1 sets when the fifo is full and another character is fully assembled.
// - bit 0 sets when a character is available and clears when all receive data has been read.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`include "uls_defines.svh"
module uls_line_status (
	input  wire logic                   core_clk,
	input  wire logic                   resetn,
	input  wire logic [`ULS_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	input  wire logic                   rx_char_done,
	input  wire logic                   rx_stop_ok,
	input  wire logic                   rx_parity_bit,
	input  wire logic [7:0]             rx_data_xor,
	input  wire logic                   rx_buf_read,
	input  wire logic                   rx_in,
	input  wire logic                   bit_tick,
	input  wire logic [`ULS_BRK_W-1:0]  char_bits,
	input  wire logic                   tx_hold_load,
	input  wire logic                   tx_hold_to_shift,
	input  wire logic                   tx_shift_busy,
	output logic                        irq
);
	logic [7:0]               status_q, status_d;
	logic [`ULS_CNT_W-1:0]    rx_cnt_q, rx_cnt_d;
	logic [`ULS_CNT_W-1:0]    err_cnt_q, err_cnt_d;
	logic [`ULS_FIFO_DEPTH-1:0] err_mem_q, err_mem_d;
	logic [3:0]               wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [4:0]               ctrl_q, ctrl_d;
	logic [`ULS_IRQ_W-1:0]    ist_q, ist_d, imask_q, imask_d;
	logic [7:0]               rdata_d;
	logic                     irq_d;
	logic                     brk_pulse;
	logic                     fifo_mode, stat_rd, iid_rd, par_bad, char_err, fifo_full;
	logic                     push, pop, line_evt;

	// an error is any of parity, framing or break
	function automatic logic err_of(input logic p, input logic f, input logic b);
		return p | f | b;
	endfunction

	uls_break_det u_brk (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.bit_tick    (bit_tick),
		.char_bits   (char_bits),
		.rx_in       (rx_in),
		.break_pulse (brk_pulse)
	);

	// decoded strobes and receive qualifiers
	assign fifo_mode = ctrl_q[`ULS_CTRL_FIFO];
	assign stat_rd   = reg_rd && (reg_addr == `ULS_OFF_STATUS);
	assign iid_rd    = reg_rd && (reg_addr == `ULS_OFF_IID);
	assign par_bad   = ctrl_q[`ULS_CTRL_LINE] &&
		((^rx_data_xor ^ rx_parity_bit) != ctrl_q[`ULS_CTRL_PARODD]);
	assign char_err  = err_of(par_bad, !rx_stop_ok, brk_pulse);
	assign fifo_full = (rx_cnt_q == 5'(`ULS_FIFO_DEPTH));
	assign push      = (rx_char_done || brk_pulse) && !(fifo_mode ? fifo_full : 1'b0);
	assign pop       = rx_buf_read && (rx_cnt_q != '0);

	// receive occupancy and per-entry error tags; a full fifo drops the new char
	always_comb begin
		rx_cnt_d  = rx_cnt_q;
		err_cnt_d = err_cnt_q;
		err_mem_d = err_mem_q;
		wr_ptr_d  = wr_ptr_q;
		rd_ptr_d  = rd_ptr_q;
		if (!fifo_mode) begin
			// single buffer: overwrite keeps one word
			if (push) begin
				rx_cnt_d = 5'h01;
			end else if (pop) begin
				rx_cnt_d = '0;
			end
			err_cnt_d = '0;
			wr_ptr_d  = '0;
			rd_ptr_d  = '0;
		end else begin
			if (push) begin
				err_mem_d[wr_ptr_q] = char_err;
				wr_ptr_d = wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_d = rd_ptr_q + 1'b1;
			end
			rx_cnt_d  = rx_cnt_q + 5'(push) - 5'(pop);
			err_cnt_d = err_cnt_q + 5'(push && char_err) - 5'(pop && err_mem_q[rd_ptr_q]);
		end
	end

	// status word next value; set terms are applied after clears so sets win
	always_comb begin
		status_d = status_q;
		if (stat_rd) begin
			status_d[`ULS_BIT_OE] = 1'b0;
			status_d[`ULS_BIT_PE] = 1'b0;
			status_d[`ULS_BIT_FE] = 1'b0;
			status_d[`ULS_BIT_BI] = 1'b0;
			status_d[`ULS_BIT_FERR] = 1'b0;
		end
		if (rx_char_done && par_bad) begin
			status_d[`ULS_BIT_PE] = 1'b1;
		end
		if (rx_char_done && !rx_stop_ok) begin
			status_d[`ULS_BIT_FE] = 1'b1;
		end
		if (brk_pulse) begin
			status_d[`ULS_BIT_BI] = 1'b1;
		end
		if (!fifo_mode && rx_char_done && status_q[`ULS_BIT_DR] && !pop) begin
			status_d[`ULS_BIT_OE] = 1'b1;
		end
		if (fifo_mode && rx_char_done && fifo_full) begin
			status_d[`ULS_BIT_OE] = 1'b1;
		end
		// summary stays while erroneous chars remain after the read
		if (fifo_mode && (err_cnt_d != '0) && (!stat_rd || status_q[`ULS_BIT_FERR] ||
			(push && char_err))) begin
			status_d[`ULS_BIT_FERR] = 1'b1;
		end
		if (fifo_mode && stat_rd && (err_cnt_d != '0)) begin
			status_d[`ULS_BIT_FERR] = 1'b1;
		end
		if (!fifo_mode) begin
			status_d[`ULS_BIT_FERR] = 1'b0;
		end
		status_d[`ULS_BIT_DR] = (rx_cnt_d != '0);
		// holding empty: a load clears it, a move to the shifter sets it
		if (tx_hold_load) begin
			status_d[`ULS_BIT_TX_HOLDING_EMPTY_FLAG] = 1'b0;
		end
		if (tx_hold_to_shift) begin
			status_d[`ULS_BIT_TX_HOLDING_EMPTY_FLAG] = 1'b1;
		end
		status_d[`ULS_BIT_TEMT] = status_d[`ULS_BIT_TX_HOLDING_EMPTY_FLAG] && !tx_shift_busy;
	end

	// line event for the priority-1 condition: any of bits 1..4 newly set
	assign line_evt = |(status_d[`ULS_BIT_BI:`ULS_BIT_OE] & ~status_q[`ULS_BIT_BI:`ULS_BIT_OE]);

	// control, mask and sticky interrupt status; set beats write-one-clear
	always_comb begin
		ctrl_d  = ctrl_q;
		imask_d = imask_q;
		ist_d   = ist_q;
		if (reg_wr && (reg_addr == `ULS_OFF_CTRL)) begin
			ctrl_d = reg_wdata[4:0];
		end else if (reg_wr && (reg_addr == `ULS_OFF_INT_MASK)) begin
			imask_d = reg_wdata[`ULS_IRQ_W-1:0];
		end else if (reg_wr && (reg_addr == `ULS_OFF_INT_STAT)) begin
			ist_d = ist_q & ~reg_wdata[`ULS_IRQ_W-1:0];
		end
		if (iid_rd && !ist_q[`ULS_IRQ_LINE]) begin
			ist_d[`ULS_IRQ_TX_HOLDING_EMPTY_FLAG] = 1'b0;
		end
		if (line_evt && ctrl_q[`ULS_CTRL_LSIE]) begin
			ist_d[`ULS_IRQ_LINE] = 1'b1;
		end
		if (tx_hold_to_shift) begin
			ist_d[`ULS_IRQ_TX_HOLDING_EMPTY_FLAG] = 1'b1;
		end
		irq_d = |(ist_d & imask_d);
	end

	// read mux; unmapped offsets read zero, data stands one cycle later
	always_comb begin
		rdata_d = '0;
		if (!reg_rd) begin
			rdata_d = '0;
		end else if (reg_addr == `ULS_OFF_STATUS) begin
			rdata_d = status_q;
		end else if (reg_addr == `ULS_OFF_INT_STAT) begin
			rdata_d = {6'h00, ist_q};
		end else if (reg_addr == `ULS_OFF_INT_MASK) begin
			rdata_d = {6'h00, imask_q};
		end else if (reg_addr == `ULS_OFF_CTRL) begin
			rdata_d = {3'h0, ctrl_q};
		end else if (reg_addr == `ULS_OFF_IID) begin
			// line status outranks holding empty
			rdata_d = ist_q[`ULS_IRQ_LINE] ? `ULS_IID_LINE :
				(ist_q[`ULS_IRQ_TX_HOLDING_EMPTY_FLAG] ? `ULS_IID_TX_HOLDING_EMPTY_FLAG : `ULS_IID_NONE);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			status_q  <= `ULS_STATUS_RST;
			rx_cnt_q  <= '0;
			err_cnt_q <= '0;
			err_mem_q <= '0;
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			ctrl_q    <= '0;
			imask_q   <= '0;
			ist_q     <= '0;
			reg_rdata <= '0;
			irq       <= 1'b0;
		end else begin
			status_q  <= status_d;
			rx_cnt_q  <= rx_cnt_d;
			err_cnt_q <= err_cnt_d;
			err_mem_q <= err_mem_d;
			wr_ptr_q  <= wr_ptr_d;
			rd_ptr_q  <= rd_ptr_d;
			ctrl_q    <= ctrl_d;
			imask_q   <= imask_d;
			ist_q     <= ist_d;
			reg_rdata <= rdata_d;
			irq       <= irq_d;
		end
	end

	// checks
	no_sum_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!fifo_mode |=> !status_q[`ULS_BIT_FERR] || $past(fifo_mode)) else $error("summary set outside fifo mode");
	sum_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		fifo_mode && push && char_err |=> status_q[`ULS_BIT_FERR] || !fifo_mode) else $error("summary not set");
	sum_clr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		fifo_mode && stat_rd && err_cnt_d == '0 && !(push && char_err) |=> !status_q[`ULS_BIT_FERR]) else $error("summary not cleared");
	temt_rel_a: assert property (@(posedge core_clk) disable iff (!resetn)
		status_q[`ULS_BIT_TEMT] |-> status_q[`ULS_BIT_TX_HOLDING_EMPTY_FLAG]) else $error("tx empty without holding empty");
	tx_holding_empty_flag_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		tx_hold_to_shift |=> status_q[`ULS_BIT_TX_HOLDING_EMPTY_FLAG] && ist_q[`ULS_IRQ_TX_HOLDING_EMPTY_FLAG]) else $error("holding empty not set");
	tx_holding_empty_flag_clr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		tx_hold_load && !tx_hold_to_shift |=> !status_q[`ULS_BIT_TX_HOLDING_EMPTY_FLAG]) else $error("holding empty not cleared");
	lsi_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		ctrl_q[`ULS_CTRL_LSIE] && line_evt |=> ist_q[`ULS_IRQ_LINE]) else $error("line status condition missing");
	fe_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
		stat_rd && rx_char_done && !rx_stop_ok |=> status_q[`ULS_BIT_FE]) else $error("framing error lost");
	fe_clr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		stat_rd && !rx_char_done |=> !status_q[`ULS_BIT_FE] && !status_q[`ULS_BIT_PE]) else $error("error not cleared by read");
	ovr_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!fifo_mode && rx_char_done && status_q[`ULS_BIT_DR] && !pop |=> status_q[`ULS_BIT_OE]) else $error("overrun missed");
	ovr_fifo_a: assert property (@(posedge core_clk) disable iff (!resetn)
		fifo_mode && rx_char_done && fifo_full |=> status_q[`ULS_BIT_OE]) else $error("fifo overrun missed");
	dr_track_a: assert property (@(posedge core_clk) disable iff (!resetn)
		status_q[`ULS_BIT_DR] == (rx_cnt_q != '0)) else $error("data ready wrong");
	irq_lvl_a: assert property (@(posedge core_clk) disable iff (!resetn)
		irq == |(ist_q & imask_q)) else $error("irq level wrong");
	iid_clr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		iid_rd && !ist_q[`ULS_IRQ_LINE] && !tx_hold_to_shift |=> !ist_q[`ULS_IRQ_TX_HOLDING_EMPTY_FLAG]) else $error("tx_holding_empty_flag condition not cleared");

	ovr_seen_c: cover property (@(posedge core_clk) disable iff (!resetn) status_q[`ULS_BIT_OE]);
	brk_seen_c: cover property (@(posedge core_clk) disable iff (!resetn) status_q[`ULS_BIT_BI]);
	sum_seen_c: cover property (@(posedge core_clk) disable iff (!resetn) status_q[`ULS_BIT_FERR] ##1 stat_rd);
	irq_seen_c: cover property (@(posedge core_clk) disable iff (!resetn) irq);
endmodule // uls_line_status

// File: design/uls_defines.svh
// offsets, field positions and constants for the line status logic
`ifndef ULS_DEFINES_SVH
`define ULS_DEFINES_SVH
`define ULS_ADDR_W        3
`define ULS_OFF_STATUS    3'h5
`define ULS_OFF_INT_STAT  3'h0
`define ULS_OFF_INT_MASK  3'h1
`define ULS_OFF_CTRL      3'h2
`define ULS_OFF_IID       3'h3
`define ULS_BIT_DR        0
`define ULS_BIT_OE        1
`define ULS_BIT_PE        2
`define ULS_BIT_FE        3
`define ULS_BIT_BI        4
`define ULS_BIT_TX_HOLDING_EMPTY_FLAG      5
`define ULS_BIT_TEMT      6
`define ULS_BIT_FERR      7
`define ULS_IRQ_LINE      0
`define ULS_IRQ_TX_HOLDING_EMPTY_FLAG      1
`define ULS_IRQ_W         2
`define ULS_CTRL_FIFO     0
`define ULS_CTRL_LSIE     1
`define ULS_CTRL_PARODD   2
`define ULS_CTRL_LINE     4
`define ULS_FIFO_DEPTH    16
`define ULS_CNT_W         5
`define ULS_STATUS_RST    8'h60
`define ULS_IID_NONE      8'h01
`define ULS_IID_LINE      8'h06
`define ULS_IID_TX_HOLDING_EMPTY_FLAG      8'h02
`define ULS_BRK_W         8
`endif

// File: design/uls_pkg.sv
// types for the line status logic
package uls_pkg;
	typedef enum logic [1:0] {
		ULS_BRK_IDLE = 2'b00,
		ULS_BRK_LOW  = 2'b01,
		ULS_BRK_HELD = 2'b10
	} uls_brk_state_type;
endpackage

// File: design/uls_break_det.sv
// break detector: counts a low serial input over one character time
`timescale 1ns/1ns
`include "uls_defines.svh"
module uls_break_det (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic                  bit_tick,
	input  wire logic [`ULS_BRK_W-1:0] char_bits,
	input  wire logic                  rx_in,
	output logic                       break_pulse
);
	uls_pkg::uls_brk_state_type state_q, state_d;
	logic [`ULS_BRK_W-1:0]      cnt_q, cnt_d;
	logic                       pulse_d;

	// count bit times while the line is spacing; fire once per break
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		pulse_d = 1'b0;
		case (state_q)
			uls_pkg::ULS_BRK_IDLE: begin
				cnt_d = '0;
				if (!rx_in) begin
					state_d = uls_pkg::ULS_BRK_LOW;
				end
			end
			uls_pkg::ULS_BRK_LOW: begin
				if (rx_in) begin
					state_d = uls_pkg::ULS_BRK_IDLE;
				end else if (bit_tick) begin
					// longer than a full character: one bit time past char_bits
					if (cnt_q >= char_bits) begin
						pulse_d = 1'b1;
						state_d = uls_pkg::ULS_BRK_HELD;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
			end
			uls_pkg::ULS_BRK_HELD: begin
				if (rx_in) begin
					state_d = uls_pkg::ULS_BRK_IDLE;
				end
			end
			default: state_d = uls_pkg::ULS_BRK_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= uls_pkg::ULS_BRK_IDLE;
			cnt_q       <= '0;
			break_pulse <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			break_pulse <= pulse_d;
		end
	end

	brk_once_a: assert property (@(posedge core_clk) disable iff (!resetn)
		break_pulse |=> !break_pulse) else $error("break pulse longer than one cycle");
endmodule // uls_break_det

// File: test/uls_serial_peer.sv
// behavioural far-end receive path: characters, break runs and bit ticks
`timescale 1ns/1ns
`include "uls_defines.svh"
module uls_serial_peer (
	input  wire logic                  core_clk,
	output logic                       rx_char_done,
	output logic                       rx_stop_ok,
	output logic                       rx_parity_bit,
	output logic [7:0]                 rx_data_xor,
	output logic                       rx_in,
	output logic                       bit_tick,
	output logic [`ULS_BRK_W-1:0]      char_bits
);
	logic [1:0] div_q;
	// idle line is high, qualifiers start inverted so stale values never match
	initial begin
		div_q = 2'h0;
		bit_tick = 1'b0;
		rx_char_done = 1'b0;
		rx_stop_ok = 1'b0;
		rx_parity_bit = 1'b1;
		rx_data_xor = 8'hff;
		rx_in = 1'b1;
		char_bits = 8'h0a;
	end
	// one bit time every four clocks keeps break runs short
	always @(posedge core_clk) begin
		div_q <= div_q + 2'h1;
		bit_tick <= (div_q == 2'h3);
	end
	// one assembled character, qualifiers flipped once the pulse is gone
	task automatic send_char(input logic [7:0] d, input logic p, input logic s);
		@(posedge core_clk);
		rx_data_xor <= d;
		rx_parity_bit <= p;
		rx_stop_ok <= s;
		rx_char_done <= 1'b1;
		@(posedge core_clk);
		rx_char_done <= 1'b0;
		rx_data_xor <= ~d;
		rx_parity_bit <= ~p;
		rx_stop_ok <= ~s;
	endtask
	// spacing level for more than a whole character time
	task automatic hold_low();
		@(posedge core_clk);
		rx_in <= 1'b0;
		repeat (char_bits + 3) @(posedge bit_tick);
		@(posedge core_clk);
		rx_in <= 1'b1;
	endtask
endmodule // uls_serial_peer

// File: test/uls_line_status_tb_top.sv
// self-checking bench for the line status logic
`timescale 1ns/1ns
`include "uls_defines.svh"
module uls_line_status_tb_top;
	logic                   core_clk;
	logic                   resetn;
	logic [`ULS_ADDR_W-1:0] reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [7:0]             reg_rdata;
	logic                   rx_char_done;
	logic                   rx_stop_ok;
	logic                   rx_parity_bit;
	logic [7:0]             rx_data_xor;
	logic                   rx_buf_read;
	logic                   rx_in;
	logic                   bit_tick;
	logic [`ULS_BRK_W-1:0]  char_bits;
	logic                   tx_hold_load;
	logic                   tx_hold_to_shift;
	logic                   tx_shift_busy;
	logic                   irq;
	logic [7:0]             rd_v;
	int                     failures;
	int                     checks;
	int                     cycles;
	// rows: control, data, parity, stop ok, status after one character
	logic [39:0] rows [6] = '{40'h1003000161, 40'h1001000165, 40'h1003000069,
		40'h1401000161, 40'h1403000165, 40'h0001000161};

	uls_line_status u_uls_line_status (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_char_done(rx_char_done), .rx_stop_ok(rx_stop_ok),
		.rx_parity_bit(rx_parity_bit), .rx_data_xor(rx_data_xor),
		.rx_buf_read(rx_buf_read), .rx_in(rx_in), .bit_tick(bit_tick),
		.char_bits(char_bits), .tx_hold_load(tx_hold_load),
		.tx_hold_to_shift(tx_hold_to_shift), .tx_shift_busy(tx_shift_busy), .irq(irq));
	uls_serial_peer u_uls_serial_peer (.core_clk(core_clk), .rx_char_done(rx_char_done),
		.rx_stop_ok(rx_stop_ok), .rx_parity_bit(rx_parity_bit),
		.rx_data_xor(rx_data_xor), .rx_in(rx_in), .bit_tick(bit_tick),
		.char_bits(char_bits));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic conclude();
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			conclude();
		end
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
		input string n);
		rd(a);
		chk(n, e & m, rd_v & m);
	endtask
	// one-cycle pulses of holding load, move to shifter and buffer read
	task automatic ev(input logic ld, input logic mv, input logic br);
		@(posedge core_clk);
		tx_hold_load <= ld;
		tx_hold_to_shift <= mv;
		rx_buf_read <= br;
		@(posedge core_clk);
		tx_hold_load <= 1'b0;
		tx_hold_to_shift <= 1'b0;
		rx_buf_read <= 1'b0;
	endtask

	initial begin
		resetn = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{rx_buf_read, tx_hold_load, tx_hold_to_shift, tx_shift_busy} = '0;
		{rd_v, failures, checks, cycles} = '0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rchk(3'h5, 8'h60, 8'hff, "status reset");
		rchk(3'h7, 8'h00, 8'hff, "unmapped read");
		chk("irq reset", 8'h00, {7'h0, irq});
		wr(3'h5, 8'h00);
		rchk(3'h5, 8'h60, 8'hff, "status read only");
		foreach (rows[i]) begin
			wr(3'h2, rows[i][39:32]);
			u_uls_serial_peer.send_char(rows[i][31:24], rows[i][16], rows[i][8]);
			rchk(3'h5, rows[i][7:0], 8'hff, "row status");
			rchk(3'h5, 8'h61, 8'hff, "row cleared");
			ev(1'b0, 1'b0, 1'b1);
			rchk(3'h5, 8'h60, 8'hff, "row drained");
		end
		// unread buffer overwritten, then an error racing a clearing read
		wr(3'h2, 8'h10);
		repeat (2) u_uls_serial_peer.send_char(8'h03, 1'b0, 1'b1);
		rchk(3'h5, 8'h63, 8'hff, "overrun");
		fork
			rd(3'h5);
			u_uls_serial_peer.send_char(8'h01, 1'b0, 1'b1);
		join
		rchk(3'h5, 8'h04, 8'h04, "error kept");
		ev(1'b0, 1'b0, 1'b1);
		// with the enable set, a break raises the line condition
		wr(3'h0, 8'hff);
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h02);
		u_uls_serial_peer.hold_low();
		repeat (2) @(posedge core_clk);
		chk("irq line", 8'h01, {7'h0, irq});
		rchk(3'h3, 8'h06, 8'hff, "id line");
		rchk(3'h5, 8'h10, 8'h10, "break");
		wr(3'h0, 8'h01);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 8'h00, {7'h0, irq});
		ev(1'b0, 1'b0, 1'b1);
		// transmit path: load, move to busy shifter, then shifter idle
		ev(1'b1, 1'b0, 1'b0);
		rchk(3'h5, 8'h00, 8'h60, "tx loaded");
		tx_shift_busy <= 1'b1;
		ev(1'b0, 1'b1, 1'b0);
		rchk(3'h5, 8'h20, 8'h60, "tx moved");
		rchk(3'h0, 8'h02, 8'h02, "holding int");
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(3'h1, 8'h03);
		repeat (2) @(posedge core_clk);
		chk("irq holding", 8'h01, {7'h0, irq});
		rchk(3'h3, 8'h02, 8'hff, "id holding");
		repeat (2) @(posedge core_clk);
		chk("irq id read", 8'h00, {7'h0, irq});
		@(posedge core_clk);
		tx_shift_busy <= 1'b0;
		rchk(3'h5, 8'h60, 8'h60, "tx empty");
		// fifo mode: error summary, transmit fifo flag, overrun on full
		wr(3'h2, 8'h11);
		u_uls_serial_peer.send_char(8'h01, 1'b0, 1'b1);
		u_uls_serial_peer.send_char(8'h03, 1'b0, 1'b1);
		rchk(3'h5, 8'he5, 8'hff, "fifo error");
		rchk(3'h5, 8'he1, 8'hff, "fifo error kept");
		ev(1'b0, 1'b0, 1'b1);
		rd(3'h5);
		rchk(3'h5, 8'h61, 8'hff, "fifo error gone");
		ev(1'b0, 1'b0, 1'b1);
		ev(1'b1, 1'b0, 1'b0);
		rchk(3'h5, 8'h00, 8'h20, "fifo tx written");
		ev(1'b0, 1'b1, 1'b0);
		rchk(3'h5, 8'h20, 8'h20, "fifo tx empty");
		repeat (17) u_uls_serial_peer.send_char(8'h03, 1'b0, 1'b1);
		rchk(3'h5, 8'h03, 8'h83, "fifo overrun");
		repeat (16) ev(1'b0, 1'b0, 1'b1);
		rchk(3'h5, 8'h00, 8'h01, "fifo drained");
		conclude();
	end
endmodule // uls_line_status_tb_top
